// *** inc/framer_regs.svh ***
// Constants for the serial telegram follower framer
`ifndef FRAMER_REGS_SVH
`define FRAMER_REGS_SVH
`define FRM_CLK_PERIOD_NS 25
`define FRM_DATA_BITS     8
`define FRM_CHAR_BITS     11
`define FRM_START_CHAR    8'h02
`define FRM_ADDR_FMT_BIT  7
`define FRM_BCAST_ADDR    7'h00
`define FRM_LEN_OVERHEAD  8'h02
`define FRM_FIFO_DEPTH    8
`define FRM_CHK_INIT      8'h00
`endif

// *** inc/framer_pkg.sv ***
// State types for the serial telegram follower framer
package framer_pkg;
   typedef enum logic [4:0] {
      rs_idle = 5'h01,
      rs_len  = 5'h02,
      rs_adr  = 5'h04,
      rs_data = 5'h08,
      rs_chk  = 5'h10
   } rx_state_t;
   typedef enum logic [7:0] {
      ts_idle = 8'h01,
      ts_wait = 8'h02,
      ts_stx  = 8'h04,
      ts_len  = 8'h08,
      ts_adr  = 8'h10,
      ts_data = 8'h20,
      ts_chk  = 8'h40,
      ts_end  = 8'h80
   } tx_state_t;
endpackage

// *** verilog/byte_fifo.sv ***
// Small synchronous FIFO with valid/ready on both sides and a flush
module byte_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic         flush,
   // Fill side
   input  wire logic [W-1:0] in_data,
   input  wire logic         in_valid,
   output logic              in_ready,
   // Drain side
   output logic [W-1:0]      out_data,
   output logic              out_valid,
   input  wire logic         out_ready
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;
   logic [W-1:0]  mem [D];
   logic [AW-1:0] wr_r;
   logic [AW-1:0] rd_r;
   logic [AW:0]   cnt_r;
   logic [AW:0]   cnt_nxt;
   logic          push;
   logic          pop;

   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem[rd_r];

   function automatic logic [AW-1:0] inc_ptr(input logic [AW-1:0] p);
      inc_ptr = (p == AW'(D - 1)) ? '0 : p + 1'b1;
   endfunction

   always_comb begin
      cnt_nxt = cnt_r;
      if (push && !pop) begin
         cnt_nxt = cnt_r + 1'b1;
      end else if (pop && !push) begin
         cnt_nxt = cnt_r - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_r] <= in_data;
      end
   end

   // Ready is registered so the top sees it straight from a flop
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wr_r     <= '0;
         rd_r     <= '0;
         cnt_r    <= '0;
         in_ready <= 1'b0;
      end else if (flush) begin
         wr_r     <= '0;
         rd_r     <= '0;
         cnt_r    <= '0;
         in_ready <= 1'b1;
      end else begin
         if (push) wr_r <= inc_ptr(wr_r);
         if (pop) rd_r <= inc_ptr(rd_r);
         cnt_r    <= cnt_nxt;
         in_ready <= (cnt_nxt < (AW+1)'(D));
      end
   end
endmodule // byte_fifo

// *** verilog/char_uart.sv ***
// Character serialiser and deserialiser for the half-duplex line
`include "framer_regs.svh"
module char_uart #(
   parameter int DIV_W = 16
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             nrst,
   // Character format
   input  wire logic [DIV_W-1:0] baud_div,
   input  wire logic             parity_en,
   input  wire logic             two_stop,
   // Receive
   input  wire logic             rx_in,
   output logic [7:0]            rx_data,
   output logic                  rx_done,
   output logic                  rx_err,
   // Transmit
   input  wire logic [7:0]       tx_data,
   input  wire logic             tx_start,
   output logic                  tx_idle,
   output logic                  tx_out
);
   logic             rx_busy_r;
   logic [DIV_W-1:0] rx_cnt_r;
   logic [3:0]       rx_bit_r;
   logic [9:0]       rx_sh_r;
   logic [3:0]       rx_last;
   logic [7:0]       rx_byte;
   logic [DIV_W-1:0] tx_cnt_r;
   logic [3:0]       tx_left_r;
   logic [12:0]      tx_sh_r;

   assign rx_last = parity_en ? 4'hA : 4'h9;
   assign rx_byte = parity_en ? rx_sh_r[8:1] : rx_sh_r[9:2];
   assign tx_idle = (tx_left_r == 4'h0);

   // Sampling at mid-bit; a glitch on the start bit restarts the hunt
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rx_busy_r <= 1'b0;
         rx_cnt_r  <= '0;
         rx_bit_r  <= 4'h0;
         rx_sh_r   <= 10'h000;
         rx_data   <= 8'h00;
         rx_done   <= 1'b0;
         rx_err    <= 1'b0;
      end else begin
         rx_done <= 1'b0;
         if (!rx_busy_r) begin
            if (!rx_in) begin
               rx_busy_r <= 1'b1;
               rx_cnt_r  <= baud_div >> 1;
               rx_bit_r  <= 4'h0;
            end
         end else if (rx_cnt_r != '0) begin
            rx_cnt_r <= rx_cnt_r - 1'b1;
         end else begin
            rx_cnt_r <= baud_div - 1'b1;
            rx_bit_r <= rx_bit_r + 1'b1;
            if (rx_bit_r == 4'h0) begin
               if (rx_in) rx_busy_r <= 1'b0;
            end else if (rx_bit_r == rx_last) begin
               // Stop bit: parity over data plus parity bit must be even
               rx_busy_r <= 1'b0;
               rx_done   <= 1'b1;
               rx_data   <= rx_byte;
               rx_err    <= !rx_in ||
                            (parity_en && (^rx_sh_r[9:1]));
            end else begin
               rx_sh_r <= {rx_in, rx_sh_r[9:1]};
            end
         end
      end
   end

   // Frame: start, 8 data, even parity when parity_en, stop (one or two)
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tx_cnt_r  <= '0;
         tx_left_r <= 4'h0;
         tx_sh_r   <= 13'h1FFF;
         tx_out    <= 1'b1;
      end else if (tx_start && tx_idle) begin
         tx_cnt_r  <= '0;
         tx_sh_r   <= parity_en ? {3'b111, ^tx_data, tx_data, 1'b0}
                                : {4'b1111, tx_data, 1'b0};
         tx_left_r <= 4'hB + {3'b000, parity_en} + {3'b000, two_stop};
      end else if (!tx_idle) begin
         if (tx_cnt_r != '0) begin
            tx_cnt_r <= tx_cnt_r - 1'b1;
         end else begin
            tx_cnt_r  <= baud_div - 1'b1;
            tx_out    <= tx_sh_r[0];
            tx_sh_r   <= {1'b1, tx_sh_r[12:1]};
            tx_left_r <= tx_left_r - 1'b1;
         end
      end
   end

   tx_parity_a: assert property (@(posedge clk) disable iff (!nrst)
      (tx_start && tx_idle && parity_en) |=> (^tx_sh_r[9:1] == 1'b0))
      else $error("transmit parity not even");
endmodule // char_uart

// *** verilog/serial_telegram_follower_framer.sv ***
// Follower-side telegram framer for a half-duplex two-wire serial bus
`include "framer_regs.svh"
module serial_telegram_follower_framer #(
   parameter int DIV_W = 16,
   parameter int CNT_W = 24
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             nrst,
   // Bus pins
   input  wire logic             line_rx,
   output logic                  line_tx,
   output logic                  line_de,
   // Configuration
   input  wire logic [6:0]       own_addr,
   input  wire logic [DIV_W-1:0] baud_div,
   input  wire logic             parity_en,
   input  wire logic             two_stop,
   input  wire logic [CNT_W-1:0] min_resp_cycles,
   input  wire logic [CNT_W-1:0] max_resp_cycles,
   input  wire logic [CNT_W-1:0] max_gap_cycles,
   // Received telegram
   output logic [7:0]            rx_byte,
   output logic                  rx_byte_valid,
   output logic                  frame_ok,
   output logic                  frame_err,
   output logic                  frame_bcast,
   // Reply
   output logic                  reply_req,
   input  wire logic             reply_go,
   input  wire logic [7:0]       reply_len,
   input  wire logic [7:0]       tx_data,
   input  wire logic             tx_valid,
   output logic                  tx_ready,
   output logic                  resp_timeout
);
   logic                  rx_meta_r;
   logic                  rx_sync_r;
   logic [7:0]            u_rx_data;
   logic                  u_rx_done;
   logic                  u_rx_err;
   logic                  u_tx_idle;
   logic                  rx_take;
   framer_pkg::rx_state_t rstate_r;
   logic [7:0]            rx_chk_r;
   logic [7:0]            rx_left_r;
   logic [7:0]            addr_r;
   logic                  match_r;
   logic                  bad_r;
   logic [CNT_W-1:0]      gap_cnt_r;
   logic                  gap_over;
   framer_pkg::tx_state_t pstate_r;
   logic [CNT_W-1:0]      resp_cnt_r;
   logic [7:0]            reply_len_r;
   logic [7:0]            tx_left_r;
   logic [7:0]            tx_chk_r;
   logic [7:0]            tx_byte_r;
   logic                  tx_start_r;
   logic                  can_send;
   logic [7:0]            f_data;
   logic                  f_valid;
   logic                  f_pop;
   logic                  f_flush_r;

   // Is this address byte for us, in the 1..126 format?
   function automatic logic addr_hit(input logic [7:0] a,
                                     input logic [6:0] own);
      addr_hit = a[`FRM_ADDR_FMT_BIT] &&
                 (a[6:0] == own || a[6:0] == `FRM_BCAST_ADDR);
   endfunction

   // Two-flop synchroniser on the line input; idle line is high
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rx_meta_r <= 1'b1;
         rx_sync_r <= 1'b1;
      end else begin
         rx_meta_r <= line_rx;
         rx_sync_r <= rx_meta_r;
      end
   end

   char_uart #(.DIV_W(DIV_W)) u_uart (
      .clk       (clk),
      .nrst      (nrst),
      .baud_div  (baud_div),
      .parity_en (parity_en),
      .two_stop  (two_stop),
      .rx_in     (rx_sync_r),
      .rx_data   (u_rx_data),
      .rx_done   (u_rx_done),
      .rx_err    (u_rx_err),
      .tx_data   (tx_byte_r),
      .tx_start  (tx_start_r),
      .tx_idle   (u_tx_idle),
      .tx_out    (line_tx)
   );

   // Reply bytes queue here; a slow source just stalls the sender
   byte_fifo #(.W(8), .D(`FRM_FIFO_DEPTH)) u_fifo (
      .clk       (clk),
      .nrst      (nrst),
      .flush     (f_flush_r),
      .in_data   (tx_data),
      .in_valid  (tx_valid),
      .in_ready  (tx_ready),
      .out_data  (f_data),
      .out_valid (f_valid),
      .out_ready (f_pop)
   );

   // Our own echo is ignored while the driver is on
   assign rx_take  = u_rx_done && !line_de;
   assign gap_over = (rstate_r != framer_pkg::rs_idle) &&
                     (gap_cnt_r > max_gap_cycles);
   assign can_send = u_tx_idle && !tx_start_r;
   assign f_pop    = (pstate_r == framer_pkg::ts_data) && can_send;

   // Inter-character gap timer
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         gap_cnt_r <= '0;
      end else if (rx_take || rstate_r == framer_pkg::rs_idle) begin
         gap_cnt_r <= '0;
      end else if (!gap_over) begin
         gap_cnt_r <= gap_cnt_r + 1'b1;
      end
   end

   // Receive telegram parser
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rstate_r      <= framer_pkg::rs_idle;
         rx_chk_r      <= `FRM_CHK_INIT;
         rx_left_r     <= 8'h00;
         addr_r        <= 8'h00;
         match_r       <= 1'b0;
         bad_r         <= 1'b0;
         rx_byte       <= 8'h00;
         rx_byte_valid <= 1'b0;
         frame_ok      <= 1'b0;
         frame_err     <= 1'b0;
         frame_bcast   <= 1'b0;
      end else begin
         rx_byte_valid <= 1'b0;
         frame_ok      <= 1'b0;
         frame_err     <= 1'b0;
         if (gap_over) begin
            rstate_r  <= framer_pkg::rs_idle;
            frame_err <= match_r;
         end else if (rx_take) begin
            rx_chk_r <= rx_chk_r ^ u_rx_data;
            if (u_rx_err) bad_r <= 1'b1;
            unique case (rstate_r)
               framer_pkg::rs_idle: begin
                  if (u_rx_data == `FRM_START_CHAR && !u_rx_err) begin
                     rstate_r <= framer_pkg::rs_len;
                     rx_chk_r <= `FRM_CHK_INIT ^ u_rx_data;
                     bad_r    <= 1'b0;
                     match_r  <= 1'b0;
                  end
               end
               framer_pkg::rs_len: begin
                  // Any length of two or more: short, long, text
                  rx_left_r <= u_rx_data - `FRM_LEN_OVERHEAD;
                  if (u_rx_data < `FRM_LEN_OVERHEAD) begin
                     rstate_r <= framer_pkg::rs_idle;
                  end else begin
                     rstate_r <= framer_pkg::rs_adr;
                  end
               end
               framer_pkg::rs_adr: begin
                  addr_r      <= u_rx_data;
                  match_r     <= addr_hit(u_rx_data, own_addr);
                  frame_bcast <= (u_rx_data[6:0] == `FRM_BCAST_ADDR);
                  rstate_r    <= (rx_left_r == 8'h00) ?
                                 framer_pkg::rs_chk : framer_pkg::rs_data;
               end
               framer_pkg::rs_data: begin
                  rx_byte       <= u_rx_data;
                  rx_byte_valid <= match_r;
                  rx_left_r     <= rx_left_r - 1'b1;
                  if (rx_left_r == 8'h01) rstate_r <= framer_pkg::rs_chk;
               end
               framer_pkg::rs_chk: begin
                  rstate_r <= framer_pkg::rs_idle;
                  if (match_r) begin
                     if (rx_chk_r == u_rx_data && !bad_r && !u_rx_err) begin
                        frame_ok <= 1'b1;
                     end else begin
                        frame_err <= 1'b1;
                     end
                  end
               end
            endcase
         end
      end
   end

   // Reply sequencer: wait window, then start, length, address, data, sum
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pstate_r     <= framer_pkg::ts_idle;
         resp_cnt_r   <= '0;
         reply_len_r  <= 8'h00;
         tx_left_r    <= 8'h00;
         tx_chk_r     <= `FRM_CHK_INIT;
         tx_byte_r    <= 8'h00;
         tx_start_r   <= 1'b0;
         line_de      <= 1'b0;
         reply_req    <= 1'b0;
         resp_timeout <= 1'b0;
         f_flush_r    <= 1'b0;
      end else begin
         tx_start_r   <= 1'b0;
         resp_timeout <= 1'b0;
         f_flush_r    <= 1'b0;
         unique case (pstate_r)
            framer_pkg::ts_idle: begin
               resp_cnt_r <= '0;
               // Only a clean, addressed, non-broadcast request opens a reply
               if (frame_ok && !frame_bcast) begin
                  pstate_r  <= framer_pkg::ts_wait;
                  reply_req <= 1'b1;
               end
            end
            framer_pkg::ts_wait: begin
               resp_cnt_r <= resp_cnt_r + 1'b1;
               if (rstate_r != framer_pkg::rs_idle) begin
                  // Master moved on; the old reply is stale
                  pstate_r  <= framer_pkg::ts_idle;
                  reply_req <= 1'b0;
                  f_flush_r <= 1'b1;
               end else if (reply_go && resp_cnt_r >= min_resp_cycles) begin
                  pstate_r    <= framer_pkg::ts_stx;
                  reply_req   <= 1'b0;
                  reply_len_r <= reply_len;
                  line_de     <= 1'b1;
               end else if (resp_cnt_r >= max_resp_cycles) begin
                  pstate_r     <= framer_pkg::ts_idle;
                  reply_req    <= 1'b0;
                  resp_timeout <= 1'b1;
                  f_flush_r    <= 1'b1;
               end
            end
            framer_pkg::ts_stx: begin
               if (can_send) begin
                  tx_byte_r  <= `FRM_START_CHAR;
                  tx_start_r <= 1'b1;
                  tx_chk_r   <= `FRM_CHK_INIT ^ `FRM_START_CHAR;
                  pstate_r   <= framer_pkg::ts_len;
               end
            end
            framer_pkg::ts_len: begin
               if (can_send) begin
                  tx_byte_r  <= reply_len_r + `FRM_LEN_OVERHEAD;
                  tx_start_r <= 1'b1;
                  tx_chk_r   <= tx_chk_r ^ (reply_len_r + `FRM_LEN_OVERHEAD);
                  pstate_r   <= framer_pkg::ts_adr;
               end
            end
            framer_pkg::ts_adr: begin
               if (can_send) begin
                  tx_byte_r  <= addr_r;
                  tx_start_r <= 1'b1;
                  tx_chk_r   <= tx_chk_r ^ addr_r;
                  tx_left_r  <= reply_len_r;
                  pstate_r   <= (reply_len_r == 8'h00) ?
                                framer_pkg::ts_chk : framer_pkg::ts_data;
               end
            end
            framer_pkg::ts_data: begin
               // An empty queue stretches the character gap; keep it fed
               if (can_send && f_valid) begin
                  tx_byte_r  <= f_data;
                  tx_start_r <= 1'b1;
                  tx_chk_r   <= tx_chk_r ^ f_data;
                  tx_left_r  <= tx_left_r - 1'b1;
                  if (tx_left_r == 8'h01) pstate_r <= framer_pkg::ts_chk;
               end
            end
            framer_pkg::ts_chk: begin
               if (can_send) begin
                  tx_byte_r  <= tx_chk_r;
                  tx_start_r <= 1'b1;
                  pstate_r   <= framer_pkg::ts_end;
               end
            end
            framer_pkg::ts_end: begin
               // Hold the driver until the last stop bit has left
               if (can_send) begin
                  line_de  <= 1'b0;
                  pstate_r <= framer_pkg::ts_idle;
               end
            end
         endcase
      end
   end

   de_reply_only_a: assert property (@(posedge clk) disable iff (!nrst)
      line_de |-> !(pstate_r inside {framer_pkg::ts_idle,
                                     framer_pkg::ts_wait}))
      else $error("driver on outside a reply");

   start_char_a: assert property (@(posedge clk) disable iff (!nrst)
      (rstate_r == framer_pkg::rs_idle && rx_take && !gap_over &&
       u_rx_data != `FRM_START_CHAR) |=> rstate_r == framer_pkg::rs_idle)
      else $error("telegram opened without start character");

   chk_clear_a: assert property (@(posedge clk) disable iff (!nrst)
      (rstate_r == framer_pkg::rs_idle ##1 rstate_r == framer_pkg::rs_len)
      |-> rx_chk_r == (`FRM_CHK_INIT ^ `FRM_START_CHAR))
      else $error("checksum not cleared at telegram start");

   addr_echo_a: assert property (@(posedge clk) disable iff (!nrst)
      (pstate_r == framer_pkg::ts_adr && can_send)
      |=> tx_start_r && tx_byte_r == addr_r)
      else $error("reply address differs from request");

   len_byte_a: assert property (@(posedge clk) disable iff (!nrst)
      (pstate_r == framer_pkg::ts_len && can_send)
      |=> tx_byte_r == reply_len_r + `FRM_LEN_OVERHEAD)
      else $error("reply length byte wrong");

   min_delay_a: assert property (@(posedge clk) disable iff (!nrst)
      (pstate_r == framer_pkg::ts_stx &&
       $past(pstate_r) == framer_pkg::ts_wait)
      |-> $past(resp_cnt_r) >= min_resp_cycles)
      else $error("reply started before minimum delay");

   max_delay_a: assert property (@(posedge clk) disable iff (!nrst)
      (pstate_r == framer_pkg::ts_wait && resp_cnt_r >= max_resp_cycles &&
       !reply_go && rstate_r == framer_pkg::rs_idle)
      |=> resp_timeout ##1 !resp_timeout)
      else $error("response timeout not flagged");

   gap_abort_a: assert property (@(posedge clk) disable iff (!nrst)
      gap_over |=> rstate_r == framer_pkg::rs_idle)
      else $error("telegram kept after long gap");

   bcast_silent_a: assert property (@(posedge clk) disable iff (!nrst)
      (frame_ok && frame_bcast && pstate_r == framer_pkg::ts_idle)
      |=> !reply_req [*2])
      else $error("reply requested for broadcast");

   bad_silent_a: assert property (@(posedge clk) disable iff (!nrst)
      (frame_err && pstate_r == framer_pkg::ts_idle) |=> !reply_req)
      else $error("reply requested for bad telegram");
endmodule // serial_telegram_follower_framer

// *** verification/master_model.sv ***
// Bus master model: sends request characters, reads reply characters
// Sole master on the line; the role never moves to another node
module master_model (
   // Clock
   input  wire logic clk,
   // Bus
   output logic      to_flw,
   input  wire logic from_flw,
   input  wire logic flw_de
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int BIT = 8;
   initial to_flw = 1'b1;
   // Start, data LSB first, even parity, one stop
   task automatic send(input logic [7:0] b);
      logic [10:0] f;
      f = {1'b1, ^b, b, 1'b0};
      for (int i = 0; i < 11; i++) begin
         @(posedge clk);
         to_flw <= f[i];
         repeat (BIT - 1) @(posedge clk);
      end
   endtask
   // Mid-bit sampling; only a driven line counts as a start bit
   task automatic recv(output logic [7:0] b, output logic pe);
      logic [9:0] f;
      while (from_flw !== 1'b0 || flw_de !== 1'b1) @(posedge clk);
      repeat (BIT / 2) @(posedge clk);
      for (int i = 0; i < 10; i++) begin
         repeat (BIT) @(posedge clk);
         f[i] = from_flw;
      end
      b = f[7:0];
      pe = (^f[8:0]) | ~f[9];
   endtask
endmodule // master_model

// *** verification/serial_telegram_follower_framer_tb.sv ***
// Bench for the follower framer: reply, discards, gap and timeout
module serial_telegram_follower_framer_tb;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin bad_count++; \
$display("[FAIL] %0t got %h want %h", $time, (a), (e)); end end
   localparam logic [7:0] ADR = 8'h85;
   logic        clk = 1'b0, nrst = 1'b0, go = 1'b0, tv = 1'b0, de_q = 1'b0;
   logic        line_rx, line_tx, line_de, rxv, fok, ferr, fbc, rreq, trdy, tmo;
   logic        two_q = 1'b0;
   logic [7:0]  td = 8'h00, rxb, rlen = 8'h04;
   logic [23:0] max_r = 24'h0007D0, min_r = 24'h000020;
   int bad_count = 0, n_compared = 0, cyc = 0, ok_n = 0, err_n = 0;
   int to_n = 0, de_n = 0, rv_n = 0;
   serial_telegram_follower_framer i_serial_telegram_follower_framer (
      .clk(clk), .nrst(nrst), .line_rx(line_rx), .line_tx(line_tx),
      .line_de(line_de), .own_addr(ADR[6:0]), .baud_div(16'h0008),
      .parity_en(1'b1), .two_stop(two_q), .min_resp_cycles(min_r),
      .max_resp_cycles(max_r), .max_gap_cycles(24'h0000C8),
      .rx_byte(rxb), .rx_byte_valid(rxv), .frame_ok(fok), .frame_err(ferr),
      .frame_bcast(fbc), .reply_req(rreq), .reply_go(go),
      .reply_len(rlen), .tx_data(td), .tx_valid(tv), .tx_ready(trdy),
      .resp_timeout(tmo));
   master_model i_master_model (.clk(clk), .to_flw(line_rx),
      .from_flw(line_tx), .flw_de(line_de));
   initial forever #12.5 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      ok_n += fok;
      err_n += ferr;
      to_n += tmo;
      de_n += (line_de && !de_q);
      de_q = line_de;
      rv_n += rxv;
      if (cyc == 30000) begin
         bad_count++;
         end_sim;
      end
   end
   task automatic send_tel(input logic [7:0] adr, input logic [7:0] flip);
      logic [7:0] c, d;
      c = 8'h06 ^ adr ^ 8'h02;
      d = 8'h10;
      i_master_model.send(8'h02);
      i_master_model.send(8'h06);
      i_master_model.send(adr);
      for (int i = 0; i < 4; i++) begin
         i_master_model.send(d);
         c ^= d;
         d++;
      end
      i_master_model.send(c ^ flip);
   endtask
   task automatic push(input logic [7:0] d);
      td <= d;
      tv <= 1'b1;
      @(posedge clk);
      while (trdy !== 1'b1) @(posedge clk);
      tv <= 1'b0;
      @(posedge clk);
   endtask
   // Reply of n data bytes; delay counted from the cycle reply_req rises
   task automatic t_reply(input logic two, input int n, input int mn);
      logic [7:0] b, e [16];
      logic pe;
      int w;
      two_q <= two;
      rlen <= 8'(n);
      min_r <= 24'(mn);
      e[0] = 8'h02;
      e[1] = 8'(n + 2);
      e[2] = ADR;
      e[n + 3] = 8'h00;
      for (int i = 0; i < n; i++) e[i + 3] = 8'hA0 + 8'(i);
      for (int i = 0; i < n + 3; i++) e[n + 3] ^= e[i];
      send_tel(ADR, 8'h00);
      for (w = 0; rreq !== 1'b1 && w < 300; w++) @(posedge clk);
      for (int i = 3; i < n + 3; i++) push(e[i]);
      go <= 1'b1;
      for (w = 0; line_de !== 1'b1 && w < 300; w++) @(posedge clk);
      `CHK(2 * n + w, mn + 1)
      for (int i = 0; i < n + 4; i++) begin
         i_master_model.recv(b, pe);
         `CHK(b, e[i])
         `CHK(pe, 1'b0)
      end
      repeat (16) @(posedge clk);
      `CHK(line_de, 1'b0)
   endtask
   // Broadcast, bad checksum, foreign address; go stays high throughout
   task automatic t_drop;
      logic [7:0] a [3] = '{8'h80, ADR, 8'h86};
      logic [7:0] f [3] = '{8'h00, 8'h01, 8'h00};
      int o, r, d, v;
      for (int i = 0; i < 3; i++) begin
         o = ok_n;
         r = err_n;
         d = de_n;
         v = rv_n;
         send_tel(a[i], f[i]);
         repeat (300) @(posedge clk);
         `CHK(ok_n - o, int'(i == 0))
         `CHK(err_n - r, int'(i == 1))
         `CHK(de_n - d, 0)
         `CHK(rreq, 1'b0)
         `CHK(rv_n - v, (i == 2) ? 0 : 4)
         `CHK(fbc, 1'(i == 0))
         `CHK(rxb, 8'h13)
      end
   endtask
   task automatic t_gap;
      int r;
      r = err_n;
      i_master_model.send(8'h02);
      i_master_model.send(8'h06);
      i_master_model.send(ADR);
      repeat (300) @(posedge clk);
      `CHK(err_n - r, 1)
   endtask
   task automatic t_timeout;
      int t;
      go <= 1'b0;
      max_r <= 24'h00012C;
      t = to_n;
      send_tel(ADR, 8'h00);
      for (int i = 0; i < 8; i++) push(8'(i));
      `CHK(trdy, 1'b0)
      repeat (400) @(posedge clk);
      `CHK(to_n - t, 1)
      `CHK(rreq, 1'b0)
      `CHK(trdy, 1'b1)
   endtask
   task automatic end_sim;
      if (bad_count == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      repeat (2) @(posedge clk);
      t_reply(1'b0, 4, 32);
      t_reply(1'b1, 8, 48);
      t_drop;
      t_gap;
      t_timeout;
      end_sim;
   end
endmodule // serial_telegram_follower_framer_tb
